// ===== src/lhs_pkg.sv
package hsync_pkg;

  // clocking
  localparam int CLK_HZ      = 100_000_000;
  localparam int LP_OSC_HZ   = 131_000;
  localparam int SYNC_CLK_HZ = 5_000_000;
  localparam int LP_DIV      = CLK_HZ / LP_OSC_HZ;
  localparam int SYNC_DIV    = CLK_HZ / SYNC_CLK_HZ;

  // register map
  localparam logic [31:0] SYNC_TIMER_VALUE_OFS          = 32'hffff0788;
  localparam logic [31:0] HEADER_SYNC_CONTROL_EDGES_OFS = 32'hffff078c;
  localparam logic [31:0] BREAK_TIMER_AND_COMPARE_OFS   = 32'hffff0790;

  // edge register fields, register reset values and break timer limit
  localparam int          STOP_CNT_LSB = 4;
  localparam int          START_CNT_LSB = 0;
  localparam logic [7:0]  EDGES_RESET  = 8'h32;
  localparam logic [11:0] CMP_RESET    = 12'h047;
  localparam logic [11:0] BREAK_MAX    = 12'hfff;
  localparam logic [15:0] SYNC_RESET   = 16'h0000;

  // status bit positions and status width
  localparam int STA_BREAK = 0;
  localparam int STA_START = 1;
  localparam int STA_STOP  = 2;
  localparam int STA_ERROR = 4;
  localparam int STA_W     = 5;

  // master framing
  localparam logic [7:0] SYNC_BYTE      = 8'h55;
  localparam logic [4:0] MIN_BREAK_BITS = 5'h0d;
  localparam logic [3:0] MAX_DATA_BYTES = 4'h8;
  localparam logic [3:0] FRAME_BITS     = 4'ha;

  function automatic logic [7:0] protect_id(input logic [5:0] id);
    logic p0;
    logic p1;
    p0 = id[0] ^ id[1] ^ id[2] ^ id[4];
    p1 = ~(id[1] ^ id[3] ^ id[4] ^ id[5]);
    return {p1, p0, id};
  endfunction

  function automatic logic [9:0] uart_frame(input logic [7:0] b);
    return {1'b1, b, 1'b0};
  endfunction

endpackage

// ===== src/lin_if.sv
`timescale 1ns/100ps
interface lin_if;
  logic master_out;
  logic master_oe;
  logic bus;

  // open-drain wire: low while an enabled driver pulls low
  assign bus = !(master_oe && !master_out);

  modport master (output master_out, output master_oe, input bus);
  modport device (input bus);
endinterface

// ===== src/lin_master_end.sv
`timescale 1ns/100ps
module lin_master_end (
  input  wire logic         core_clk,    // system clock
  input  wire logic         sys_rst,     // sync reset, high
  input  wire logic         clk_en,      // freezes state when low
  lin_if.master             lin,         // lin bus
  input  wire logic         send,        // start a frame
  input  wire logic [15:0]  bit_cycles,  // core cycles per bit
  input  wire logic [4:0]   break_bits,  // break length in bits
  input  wire logic [5:0]   frame_id,    // target identifier
  input  wire logic [3:0]   data_len,    // data bytes, 1..8
  input  wire logic [7:0]   data_byte,   // next data byte
  output logic              byte_req,    // data_byte taken
  output logic              busy         // frame in progress
);
  import hsync_pkg::*;

  typedef enum logic [1:0] {M_IDLE, M_BRK, M_DELIM, M_BYTE} mst_t;
  typedef struct packed {
    mst_t        st;
    logic [15:0] tmr;
    logic [4:0]  bits;
    logic [9:0]  shf;
    logic [3:0]  idx;
    logic [3:0]  len;
    logic [5:0]  id;
    logic        low;
    logic        req;
  } mst_state_t;

  localparam mst_state_t MST_RST = '{st: M_IDLE, default: '0};

  mst_state_t state_ff;
  mst_state_t nxt_state;
  logic       tick;

  always_comb begin
    nxt_state = state_ff;
    nxt_state.req = 1'b0;
    tick = (17'(state_ff.tmr) + 17'd1 >= 17'(bit_cycles));
    if (state_ff.st != M_IDLE) begin
      nxt_state.tmr = tick ? 16'h0000 : 16'(state_ff.tmr + 16'h0001);
    end
    unique case (state_ff.st)
      M_IDLE: begin
        if (send) begin
          nxt_state.st = M_BRK;
          nxt_state.tmr = 16'h0000;
          nxt_state.bits = (break_bits < MIN_BREAK_BITS) ? MIN_BREAK_BITS : break_bits;
          nxt_state.len = (data_len == 4'h0) ? 4'h1 :
                          (data_len > MAX_DATA_BYTES) ? MAX_DATA_BYTES : data_len;
          nxt_state.id = frame_id;
          nxt_state.low = 1'b1;
        end
      end
      M_BRK: begin
        if (tick) begin
          nxt_state.bits = 5'(state_ff.bits - 5'h01);
          if (state_ff.bits == 5'h01) begin
            nxt_state.st = M_DELIM;
            nxt_state.low = 1'b0;
          end
        end
      end
      M_DELIM: begin
        if (tick) begin
          nxt_state.st = M_BYTE;
          nxt_state.shf = uart_frame(SYNC_BYTE);
          nxt_state.bits = 5'(FRAME_BITS);
          nxt_state.idx = 4'h0;
          nxt_state.low = 1'b1;
        end
      end
      M_BYTE: begin
        if (tick) begin
          nxt_state.shf = {1'b1, state_ff.shf[9:1]};
          nxt_state.bits = 5'(state_ff.bits - 5'h01);
          nxt_state.low = ~state_ff.shf[1];
          if (state_ff.bits == 5'h01) begin
            nxt_state.idx = 4'(state_ff.idx + 4'h1);
            nxt_state.bits = 5'(FRAME_BITS);
            if (state_ff.idx == 4'h0) begin
              nxt_state.shf = uart_frame(protect_id(state_ff.id));
              nxt_state.low = 1'b1;
            end else if (state_ff.idx <= state_ff.len) begin
              nxt_state.shf = uart_frame(data_byte);
              nxt_state.req = 1'b1;
              nxt_state.low = 1'b1;
            end else begin
              nxt_state.st = M_IDLE;
              nxt_state.low = 1'b0;
            end
          end
        end
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      state_ff <= MST_RST;
    end else if (clk_en) begin
      state_ff <= nxt_state;
    end
  end

  assign lin.master_out = 1'b0;
  assign lin.master_oe  = state_ff.low;
  assign byte_req       = state_ff.req;
  assign busy           = (state_ff.st != M_IDLE);

endmodule

// ===== src/header_sync_unit.sv
`timescale 1ns/100ps
module header_sync_unit (
  input  wire logic         core_clk,      // system clock
  input  wire logic         sys_rst,       // sync reset, high
  input  wire logic         clk_en,        // freezes state when low
  lin_if.device             lin,           // lin bus
  input  wire logic [31:0]  reg_addr,      // register address
  input  wire logic         reg_wr,        // write strobe
  input  wire logic         reg_rd,        // read strobe
  input  wire logic [15:0]  reg_wdata,     // write data
  output logic      [15:0]  reg_rdata,     // read data, next cycle
  input  wire logic         reset_req,     // sets self-reset bit
  input  wire logic         stop_on_rise,  // stop edge type
  input  wire logic         gate_uart,     // gate uart receive
  input  wire logic         start_irq_en,  // start interrupt enable
  input  wire logic         stop_irq_en,   // stop interrupt enable
  input  wire logic         sync_enable,   // header sync enable
  input  wire logic         edge_clear,    // hold edge counters clear
  input  wire logic [hsync_pkg::STA_W-1:0] status_clr, // clear status bits
  output logic              reset_bit,     // self-reset bit
  output logic [hsync_pkg::STA_W-1:0] status, // sticky status
  output logic              break_irq,     // break detected pulse
  output logic              error_irq,     // break error pulse
  output logic              start_irq,     // sync start pulse
  output logic              stop_irq,      // sync stop pulse
  output logic              uart_rxd       // gated uart receive
);
  import hsync_pkg::*;

  typedef enum logic [1:0] {HS_IDLE, HS_BRK_LOW, HS_SYNC, HS_DONE} hs_t;
  typedef struct packed {
    hs_t               st;
    logic              reset_bit;
    logic [7:0]        edges;
    logic [11:0]       cmp;
    logic [11:0]       brk;
    logic              brk_run;
    logic              brk_hit;
    logic [15:0]       sync;
    logic              sync_run;
    logic              started;
    logic [3:0]        falls;
    logic [3:0]        rises;
    logic [STA_W-1:0]  status;
    logic [9:0]        lp_div;
    logic [4:0]        sy_div;
    logic              bus_q;
    logic              rxd;
    logic [15:0]       rdata;
    logic              i_brk;
    logic              i_err;
    logic              i_start;
    logic              i_stop;
  } dev_state_t;

  localparam dev_state_t DEV_RST = '{st: HS_IDLE, edges: EDGES_RESET, cmp: CMP_RESET,
                                     bus_q: 1'b1, rxd: 1'b1, default: '0};

  function automatic logic [3:0] sat_inc(input logic [3:0] v);
    return (v == 4'hf) ? v : 4'(v + 4'h1);
  endfunction

  dev_state_t state_ff;
  dev_state_t nxt_state;
  logic       fall;
  logic       rise;
  logic       lp_tick;
  logic       sy_tick;
  logic       brk_rd;
  logic [3:0] start_cnt;
  logic [3:0] stop_cnt;
  logic [3:0] stop_edges;

  always_comb begin
    nxt_state = state_ff;
    nxt_state.i_brk = 1'b0;
    nxt_state.i_err = 1'b0;
    nxt_state.i_start = 1'b0;
    nxt_state.i_stop = 1'b0;
    fall = state_ff.bus_q & ~lin.bus;
    rise = ~state_ff.bus_q & lin.bus;
    nxt_state.bus_q = lin.bus;
    lp_tick = (state_ff.lp_div == 10'(LP_DIV - 1));
    sy_tick = (state_ff.sy_div == 5'(SYNC_DIV - 1));
    nxt_state.lp_div = lp_tick ? 10'h000 : 10'(state_ff.lp_div + 10'h001);
    nxt_state.sy_div = sy_tick ? 5'h00 : 5'(state_ff.sy_div + 5'h01);
    brk_rd = reg_rd && (reg_addr == BREAK_TIMER_AND_COMPARE_OFS);
    start_cnt = state_ff.edges[START_CNT_LSB +: 4];
    stop_cnt = state_ff.edges[STOP_CNT_LSB +: 4];
    stop_edges = 4'h0;
    nxt_state.status = state_ff.status & ~status_clr;

    if (reg_rd) begin
      unique case (reg_addr)
        SYNC_TIMER_VALUE_OFS:          nxt_state.rdata = state_ff.sync;
        HEADER_SYNC_CONTROL_EDGES_OFS: nxt_state.rdata = {8'h00, state_ff.edges};
        BREAK_TIMER_AND_COMPARE_OFS:   nxt_state.rdata = {4'h0, state_ff.brk};
        default:                       nxt_state.rdata = 16'h0000;
      endcase
    end
    if (reg_wr && reg_addr == HEADER_SYNC_CONTROL_EDGES_OFS) begin
      nxt_state.edges = reg_wdata[7:0];
    end
    if (reg_wr && reg_addr == BREAK_TIMER_AND_COMPARE_OFS) begin
      nxt_state.cmp = reg_wdata[11:0];
    end

    // break timer on the low-power tick
    if (fall) begin
      nxt_state.brk = 12'h000;
      nxt_state.brk_run = 1'b1;
      nxt_state.brk_hit = 1'b0;
    end else begin
      // a read in the cycle of the rise must not hide the rise
      if (rise) begin
        nxt_state.brk_run = 1'b0;
      end else if (state_ff.brk_run && lp_tick) begin
        if (state_ff.brk == BREAK_MAX) begin
          nxt_state.brk_run = 1'b0;
          nxt_state.status[STA_ERROR] = 1'b1;
          nxt_state.i_err = 1'b1;
          nxt_state.st = HS_IDLE;
          nxt_state.sync_run = 1'b0;
        end else begin
          nxt_state.brk = 12'(state_ff.brk + 12'h001);
        end
      end
      if (brk_rd) begin
        nxt_state.brk = 12'h000;
      end
    end

    // a valid break restarts the header from any state
    if (sync_enable && state_ff.brk_run && !state_ff.brk_hit && !fall &&
        state_ff.brk == state_ff.cmp) begin
      nxt_state.brk_hit = 1'b1;
      nxt_state.status[STA_BREAK] = 1'b1;
      nxt_state.i_brk = 1'b1;
      nxt_state.st = HS_BRK_LOW;
      nxt_state.falls = 4'h1;
      nxt_state.rises = 4'h0;
      nxt_state.sync_run = 1'b0;
      nxt_state.started = 1'b0;
      if (start_cnt == 4'h1) begin
        nxt_state.sync = SYNC_RESET;
        nxt_state.sync_run = 1'b1;
        nxt_state.started = 1'b1;
        nxt_state.status[STA_START] = 1'b1;
        nxt_state.i_start = start_irq_en;
      end
    end else if (state_ff.st == HS_BRK_LOW || state_ff.st == HS_SYNC) begin
      if (fall) begin
        nxt_state.falls = sat_inc(state_ff.falls);
      end
      if (rise) begin
        nxt_state.rises = sat_inc(state_ff.rises);
        nxt_state.st = HS_SYNC;
      end
      if (fall && !state_ff.started && nxt_state.falls == start_cnt) begin
        nxt_state.sync = SYNC_RESET;
        nxt_state.sync_run = 1'b1;
        nxt_state.started = 1'b1;
        nxt_state.status[STA_START] = 1'b1;
        nxt_state.i_start = start_irq_en;
      end
      stop_edges = stop_on_rise ? nxt_state.rises : nxt_state.falls;
      if ((stop_on_rise ? rise : fall) && stop_edges == stop_cnt) begin
        nxt_state.sync_run = 1'b0;
        nxt_state.status[STA_STOP] = 1'b1;
        nxt_state.i_stop = stop_irq_en;
        nxt_state.st = HS_DONE;
      end
    end
    if (state_ff.sync_run && sy_tick) begin
      nxt_state.sync = 16'(state_ff.sync + 16'h0001);
    end

    if (edge_clear) begin
      nxt_state.falls = 4'h0;
      nxt_state.rises = 4'h0;
    end
    if (!sync_enable) begin
      nxt_state.st = HS_IDLE;
      nxt_state.sync_run = 1'b0;
    end
    nxt_state.rxd = (gate_uart && state_ff.st != HS_DONE) ? 1'b1 : lin.bus;

    if (state_ff.reset_bit) begin
      nxt_state = DEV_RST;
      nxt_state.bus_q = lin.bus;
    end
    if (reset_req) begin
      nxt_state.reset_bit = 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      state_ff <= DEV_RST;
    end else if (clk_en) begin
      state_ff <= nxt_state;
    end
  end

  assign reg_rdata = state_ff.rdata;
  assign reset_bit = state_ff.reset_bit;
  assign status    = state_ff.status;
  assign break_irq = state_ff.i_brk;
  assign error_irq = state_ff.i_err;
  assign start_irq = state_ff.i_start;
  assign stop_irq  = state_ff.i_stop;
  assign uart_rxd  = state_ff.rxd;

endmodule

// ===== test/lhs_sva.sv
`timescale 1ns/100ps
module header_sync_sva (
  input wire logic                       core_clk,   // system clock
  input wire logic                       sys_rst,    // sync reset, high
  input wire logic                       master_out, // master drive value
  input wire logic                       master_oe,  // master pulls low
  input wire logic                       reset_req,  // self-reset request
  input wire logic                       reset_bit,  // self-reset bit
  input wire logic [hsync_pkg::STA_W-1:0] status,    // sticky status
  input wire logic                       break_irq,  // break pulse
  input wire logic                       error_irq,  // break error pulse
  input wire logic                       start_irq,  // sync start pulse
  input wire logic                       stop_irq    // sync stop pulse
);
  import hsync_pkg::*;
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  AST_OPEN_DRAIN: assert property (master_out == 1'b0)
    else $error("master drives bus high");
  AST_BREAK_IN_LOW: assert property (break_irq |-> master_oe)
    else $error("break flagged outside a low pulse");
  AST_BREAK_ONE_PULSE: assert property (break_irq |=> !break_irq)
    else $error("break pulse longer than one cycle");
  AST_BREAK_FLAG: assert property (break_irq |-> ##[0:1] status[STA_BREAK])
    else $error("break flag not set");
  AST_ERROR_FLAG: assert property (error_irq |-> ##[0:1] status[STA_ERROR])
    else $error("break error flag not set");
  AST_START_AFTER_BREAK: assert property (start_irq |-> (status[STA_BREAK] || break_irq))
    else $error("sync start without break");
  AST_START_FLAG: assert property (start_irq |-> ##[0:1] status[STA_START])
    else $error("start flag not set");
  AST_STOP_FLAG: assert property (stop_irq |-> ##[0:1] status[STA_STOP])
    else $error("stop flag not set");
  AST_RESET_SET: assert property (reset_req |=> reset_bit)
    else $error("self-reset bit not set");
  AST_RESET_CLEARS: assert property (reset_bit && !reset_req |=> !reset_bit)
    else $error("self-reset bit stuck");
  AST_RESET_DEFAULT: assert property (reset_bit && !reset_req |=> status == '0)
    else $error("status kept over self-reset");
endmodule

// ===== test/lin_break_sync_timing_test.sv
`timescale 1ns/100ps
module lin_break_sync_timing_test;
  import hsync_pkg::*;
  logic        core_clk = 0, sys_rst = 1, send = 0, reg_wr = 0, reg_rd = 0, reset_req = 0;
  logic        rise = 0, en = 0, ec = 0, busy, reset_bit, rxd, byte_req, gt = 1;
  logic [1:0]  ie = 2'h2;
  logic        break_irq, error_irq, start_irq, stop_irq;
  logic [15:0] bc = 16'd200, wdata = 16'h0, rdata;
  logic [31:0] addr = 32'h0;
  logic [4:0]  bb = 5'h0, status_clr = 5'h0, status;
  logic [5:0]  fid = 6'h0;
  logic [3:0]  dl = 4'h1;
  logic [7:0]  db = 8'h0;
  logic        bus_q = 1'b1;
  int          seed = 32'h352e, mismatches = 0, n_compared = 0, cyc_n = 0, nf = 0, t_r = 0;
  int          t_f[0:7];
  int          n_si = 0, n_pi = 0, n_br = 0;

  lin_if lin_if_i ();
  lin_master_end lin_master_end_i (.core_clk(core_clk), .sys_rst(sys_rst), .clk_en(1'b1),
    .lin(lin_if_i.master), .send(send), .bit_cycles(bc), .break_bits(bb), .frame_id(fid),
    .data_len(dl), .data_byte(db), .byte_req(byte_req), .busy(busy));
  header_sync_unit header_sync_unit_i (.core_clk(core_clk), .sys_rst(sys_rst), .clk_en(1'b1),
    .lin(lin_if_i.device), .reg_addr(addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(wdata), .reg_rdata(rdata), .reset_req(reset_req), .stop_on_rise(rise),
    .gate_uart(gt), .start_irq_en(ie[0]), .stop_irq_en(ie[1]), .sync_enable(en),
    .edge_clear(ec), .status_clr(status_clr), .reset_bit(reset_bit), .status(status),
    .break_irq(break_irq), .error_irq(error_irq), .start_irq(start_irq),
    .stop_irq(stop_irq), .uart_rxd(rxd));
  header_sync_sva header_sync_sva_i (.core_clk(core_clk), .sys_rst(sys_rst),
    .master_out(lin_if_i.master_out), .master_oe(lin_if_i.master_oe),
    .reset_req(reset_req), .reset_bit(reset_bit), .status(status), .break_irq(break_irq),
    .error_irq(error_irq), .start_irq(start_irq), .stop_irq(stop_irq));

  initial begin
    forever #5 core_clk = ~core_clk;
  end

  // wire monitor: falling edge times and end of break
  always @(posedge core_clk) begin
    cyc_n++;
    if (bus_q && !lin_if_i.bus && nf < 8) begin
      t_f[nf] = cyc_n;
      nf++;
    end
    if (!bus_q && lin_if_i.bus && nf == 1)
      t_r = cyc_n;
    bus_q = lin_if_i.bus;
    if (start_irq === 1'b1)
      n_si++;
    if (stop_irq === 1'b1)
      n_pi++;
    if (byte_req === 1'b1)
      n_br++;
  end

  task automatic summarize;
    $display("counts: compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // timer values depend on divider phase: allow one tick
  task automatic near(input logic [15:0] seen, input logic [15:0] exp, input string what);
    logic [15:0] d;
    d = (seen > exp) ? seen - exp : exp - seen;
    check((d <= 16'h1) ? exp : seen, exp, what);
  endtask

  task automatic wr(input logic [31:0] a, input logic [15:0] d);
    @(posedge core_clk);
    addr <= a;
    wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [31:0] a);
    @(posedge core_clk);
    addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
  endtask

  // 0: busy high, 1: busy low, 2: break pulse
  task automatic wait_for(input int sel);
    int i;
    for (i = 0; i < 60000 && !(sel == 0 ? busy === 1'b1 : sel == 1 ? busy === 1'b0
         : break_irq === 1'b1); i++)
      @(posedge core_clk);
    if (i == 60000) begin
      mismatches++;
      summarize();
    end
  endtask

  function automatic logic [15:0] sync_exp(input logic [15:0] b, input int bits);
    return 16'(bits * int'(b) / SYNC_DIV);
  endfunction

  function automatic logic [15:0] brk_exp(input logic [15:0] b, input logic [4:0] n);
    return 16'(((n < MIN_BREAK_BITS) ? MIN_BREAK_BITS : n) * b);
  endfunction

  function automatic logic [15:0] exp_bytes(input logic [3:0] n);
    return (n == 4'h0) ? 16'h1 : (n > MAX_DATA_BYTES) ? 16'(MAX_DATA_BYTES) : 16'(n);
  endfunction

  // software view: bit time in core cycles from the sync timer
  function automatic int bit_time(input logic [15:0] sync, input int bits);
    return int'(sync) * SYNC_DIV / bits;
  endfunction

  task automatic frame(input logic [7:0] edges, input logic r, input logic [11:0] cmp,
                       input logic e_c, input int bits);
    logic brk;
    logic stp;
    int   dev;
    brk = (cmp < 12'h010);
    stp = brk && !e_c;
    wr(HEADER_SYNC_CONTROL_EDGES_OFS, {8'h0, edges});
    wr(BREAK_TIMER_AND_COMPARE_OFS, {4'h0, cmp});
    @(posedge core_clk);
    rise <= r;
    ec <= e_c;
    status_clr <= 5'h1f;
    bc <= 16'd200 + 16'($random(seed) & 63);
    bb <= 5'($random(seed) & 15);
    dl <= 4'($random(seed)) & 4'h2;
    // forced ones keep low runs well short of the short break compare
    fid <= 6'($random(seed)) | 6'h35;
    db <= 8'($random(seed)) | 8'h55;
    gt <= ~gt;
    ie <= 2'(ie + 2'h1);
    send <= 1'b1;
    @(posedge core_clk);
    status_clr <= 5'h0;
    send <= 1'b0;
    nf = 0;
    n_si = 0;
    n_pi = 0;
    n_br = 0;
    wait_for(0);
    if (brk) begin
      wait_for(2);
      rd(BREAK_TIMER_AND_COMPARE_OFS);
      near(rdata, {4'h0, cmp}, "break timer at match");
      rd(BREAK_TIMER_AND_COMPARE_OFS);
      // timer may tick once after the clearing read
      near(rdata, 16'h0, "break timer after read");
      check(16'(rxd), 16'(gt), "gated rxd");
    end
    wait_for(1);
    repeat (5) @(posedge core_clk);
    check(16'(status), {11'h0, 2'b00, stp, stp, brk}, "flags");
    check(16'(n_si), 16'(ie[0] && stp), "start pulses");
    check(16'(n_pi), 16'(ie[1] && stp), "stop pulses");
    check(16'(n_br), exp_bytes(dl), "data bytes");
    if (stp) begin
      rd(SYNC_TIMER_VALUE_OFS);
      near(rdata, sync_exp(bc, bits), "sync timer");
      dev = bit_time(rdata, bits) - int'(bc);
      check(16'((dev < 0 ? -dev : dev) * bits <= 3 * SYNC_DIV), 16'h1, "bit time");
    end
    check(16'(t_r - t_f[0]), brk_exp(bc, bb), "break length");
    check(16'(t_f[5] - t_f[1]), 16'(8 * bc), "sync falls span");
  endtask

  initial begin
    repeat (10) @(posedge core_clk);
    sys_rst <= 1'b0;
    en <= 1'b1;
    rd(HEADER_SYNC_CONTROL_EDGES_OFS);
    check(rdata, {8'h0, EDGES_RESET}, "edges reset");
    check(16'(status), 16'h0, "status reset");
    rd(32'hffff0000);
    check(rdata, 16'h0, "unmapped read");
    wr(SYNC_TIMER_VALUE_OFS, 16'h1234);
    rd(SYNC_TIMER_VALUE_OFS);
    check(rdata, SYNC_RESET, "sync timer read only");
    wr(HEADER_SYNC_CONTROL_EDGES_OFS, 16'h0062);
    @(posedge core_clk);
    reset_req <= 1'b1;
    @(posedge core_clk);
    reset_req <= 1'b0;
    #1;
    check(16'(reset_bit), 16'h1, "self-reset set");
    @(posedge core_clk);
    #1;
    check(16'(reset_bit), 16'h0, "self-reset cleared");
    rd(HEADER_SYNC_CONTROL_EDGES_OFS);
    check(rdata, {8'h0, EDGES_RESET}, "edges after self-reset");
    frame(8'h62, 1'b0, 12'h002, 1'b0, 8);
    frame(8'h52, 1'b1, 12'h002, 1'b0, 7);
    frame(8'h62, 1'b0, 12'h0ff, 1'b0, 8);
    frame(8'h62, 1'b0, 12'h002, 1'b1, 8);
    frame(8'h32, 1'b0, 12'h002, 1'b0, 2);
    summarize();
  end
endmodule
